// >>> logic/ext_access_cfg.svh
`ifndef EXT_ACCESS_CFG_SVH
`define EXT_ACCESS_CFG_SVH

// register indices, byte address is four times the index
`define PTR_SEL_IDX      10'h086
`define CLK_CTRL_IDX     10'h08E
`define CMD_IDX          10'h0A0
`define DP0_IDX          10'h0A1
`define DP1_IDX          10'h0A2
`define INDEX_IDX        10'h0A3
`define PORT2_IDX        10'h0A4
`define WDATA_IDX        10'h0A5
`define RDATA_IDX        10'h0A6
`define STATUS_IDX       10'h0A7
`define PTR_INC_IDX      10'h0A8

// field positions
`define SEL_BIT          0
`define STRETCH_MSB      2
`define STRETCH_LSB      0
`define CMD_CYC_MSB      2
`define CMD_CYC_LSB      0
`define CMD_KIND_MSB     4
`define CMD_KIND_LSB     3
`define CMD_DIR_BIT      5

// instruction kinds
`define KIND_NORMAL      2'h0
`define KIND_MOVE_INDEX  2'h1
`define KIND_MOVE_PTR    2'h2

// reset values
`define STRETCH_RST      3'h1
`define DP_RST           16'h0000
`define BYTE_RST         8'h00

// timing counts, in clocks or machine cycles
`define MC_MIN           4'h1
`define MC_MAX           4'h5
`define MOVE_BASE_MC     4'h2
`define MC_SHIFT         2
`define STROBE_W_MIN     6'h02
`define STROBE_OFS_MIN   6'h01
`define STROBE_OFS       6'h02

`endif

// >>> logic/ext_access_pkg.sv
`default_nettype none
package ext_access_pkg;

    // the four states of one machine cycle
    typedef enum logic [1:0] {
        first_state,
        second_state,
        third_state,
        fourth_state
    } mc_state_e;

    typedef logic [15:0] ext_addr_t;
    typedef logic [7:0]  byte_t;

endpackage : ext_access_pkg
`default_nettype wire

// >>> logic/external_data_access_timing.sv
// Overview of operation
// R1 - every machine cycle lasts exactly four clock periods, one state each
// R2 - states run first, second, third, fourth, then repeat
// R3 - internal work is split across state edges; mapped onto rising edges here
// R4 - one opcode fetch per machine cycle for ordinary instructions
// R5 - single cycle instructions complete in one four clock machine cycle
// R6 - ordinary instructions take one to five machine cycles
// R7 - stretch 0 to 7 gives external moves of 2 to 9 machine cycles
// R8 - stretch value comes from bits 2-0 of clock control register
// R9 - read and write strobes lengthen with the stretch
// R10 - external move: normal fetch cycle, then address and access next cycle
// R11 - only external moves stretch; processor state held during extra cycles
// R12 - indexed move: low byte from index register, high byte from port 2 latch
// R13 - pointer move: full 16-bit address from selected data pointer
// R14 - pointer select bit is bit 0 of register at 86h
// R15 - other pointer select bits have no effect and read zero
// R16 - select 0 uses first data pointer, 1 uses second
// R17 - increment on pointer select register toggles the selection
// R18 - stretch resets to 1, giving three cycle external moves
// R19 - strobe widths 2,4,8,12,16,20,24,28 clocks for stretch 0 to 7
// R20 - external address stays stable through the whole access phase
// R21 - external memory must finish within the programmed strobe width
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ext_access_cfg.svh"

module external_data_access_timing
    import ext_access_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int CNT_W  = 6
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    output var  ext_addr_t         ext_addr,
    output var  byte_t             ext_wdata,
    output var  logic              ext_data_oe,
    input  wire byte_t             ext_rdata,
    output      logic              ext_rd_n,
    output      logic              ext_wr_n,
    output var  logic              opcode_fetch,
    output var  mc_state_e         machine_state,
    output var  logic              cpu_hold,
    output var  logic              busy
);

    // register file
    logic       ptr_sel_r;
    logic [2:0] stretch_r;
    ext_addr_t  dp0_r;
    ext_addr_t  dp1_r;
    byte_t      index_r;
    byte_t      port2_r;
    byte_t      wdata_r;
    byte_t      rdata_r;

    // instruction sequencer
    logic       pending_r;
    logic [1:0] kind_r;
    logic [1:0] pend_kind_r;
    logic       pend_dir_r;
    logic [3:0] pend_cyc_r;
    logic       dir_r;
    logic [3:0] cycles_r;
    logic [3:0] mc_idx_r;
    logic       pready_r;
    logic       pslverr_r;
    logic [31:0] prdata_r;
    logic        busy_r;

    // bus decode
    logic [9:0]  idx;
    logic        aligned;
    logic        mapped;
    logic        wr_ok;
    logic        rd_phase;
    logic        cmd_ok;
    logic [3:0]  cmd_cyc;
    logic [1:0]  cmd_kind;
    logic        is_move;
    logic        start_instr;
    logic        last_mc;
    logic        acc_start;
    logic        acc_running;
    logic [31:0] rd_word;

    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign prdata  = prdata_r;
    assign busy    = busy_r;

    // address decode shared by read and write
    always_comb begin
        idx      = paddr[ADDR_W-1:2];
        aligned  = (paddr[1:0] == 2'h0);
        mapped   = aligned && ((idx == `PTR_SEL_IDX) || (idx == `CLK_CTRL_IDX)
                   || ((idx >= `CMD_IDX) && (idx <= `PTR_INC_IDX)));
        wr_ok    = psel && penable && pready_r && pwrite && mapped;
        rd_phase = psel && penable && !pready_r;
        cmd_cyc  = {1'b0, pwdata[`CMD_CYC_MSB:`CMD_CYC_LSB]};
        cmd_kind = pwdata[`CMD_KIND_MSB:`CMD_KIND_LSB];
        cmd_ok   = !busy_r && !pending_r && ((cmd_kind == `KIND_MOVE_INDEX) || (cmd_kind == `KIND_MOVE_PTR)
                   || ((cmd_kind == `KIND_NORMAL) && (cmd_cyc >= `MC_MIN) && (cmd_cyc <= `MC_MAX))); // see R6
        is_move  = (kind_r == `KIND_MOVE_INDEX) || (kind_r == `KIND_MOVE_PTR);
    end

    // read mux, unused bits read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (idx)
            `PTR_SEL_IDX:  rd_word = {31'h0000_0000, ptr_sel_r}; // see R15
            `CLK_CTRL_IDX: rd_word = {29'h0000_0000, stretch_r};
            `CMD_IDX:      rd_word = {26'h000_0000, pend_dir_r, pend_kind_r, pend_cyc_r[2:0]};
            `DP0_IDX:      rd_word = {16'h0000, dp0_r};
            `DP1_IDX:      rd_word = {16'h0000, dp1_r};
            `INDEX_IDX:    rd_word = {24'h00_0000, index_r};
            `PORT2_IDX:    rd_word = {24'h00_0000, port2_r};
            `WDATA_IDX:    rd_word = {24'h00_0000, wdata_r};
            `RDATA_IDX:    rd_word = {24'h00_0000, rdata_r};
            `STATUS_IDX:   rd_word = {22'h00_0000, pending_r, busy_r, cpu_hold, mc_idx_r, machine_state, acc_running};
            default:       rd_word = 32'h0000_0000;
        endcase
    end

    // apb handshake: one wait state, answer on second access cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= rd_phase;
            pslverr_r <= rd_phase && !mapped;
            prdata_r  <= (rd_phase && !pwrite && mapped) ? rd_word : 32'h0000_0000;
        end
    end

    // pointer select bit: write stores bit 0, increment toggles it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ptr_sel_r <= 1'b0;
        end else if (wr_ok && (idx == `PTR_SEL_IDX)) begin
            ptr_sel_r <= pwdata[`SEL_BIT]; // see R14
        end else if (wr_ok && (idx == `PTR_INC_IDX)) begin
            ptr_sel_r <= !ptr_sel_r; // see R17
        end
    end

    // stretch field of clock control register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stretch_r <= `STRETCH_RST; // see R18
        end else if (wr_ok && (idx == `CLK_CTRL_IDX)) begin
            stretch_r <= pwdata[`STRETCH_MSB:`STRETCH_LSB]; // see R8
        end
    end

    // data pointers, index register, port 2 latch, write data
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dp0_r   <= `DP_RST;
            dp1_r   <= `DP_RST;
            index_r <= `BYTE_RST;
            port2_r <= `BYTE_RST;
            wdata_r <= `BYTE_RST;
        end else if (wr_ok) begin
            if (idx == `DP0_IDX) begin
                dp0_r <= pwdata[15:0];
            end
            if (idx == `DP1_IDX) begin
                dp1_r <= pwdata[15:0];
            end
            if (idx == `INDEX_IDX) begin
                index_r <= pwdata[7:0];
            end
            if (idx == `PORT2_IDX) begin
                port2_r <= pwdata[7:0];
            end
            if (idx == `WDATA_IDX) begin
                wdata_r <= pwdata[7:0];
            end
        end
    end

    // pending command, accepted only when the sequencer is free
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pending_r   <= 1'b0;
            pend_kind_r <= `KIND_NORMAL;
            pend_dir_r  <= 1'b0;
            pend_cyc_r  <= `MC_MIN;
        end else if (wr_ok && (idx == `CMD_IDX) && cmd_ok) begin
            pending_r   <= 1'b1;
            pend_kind_r <= cmd_kind;
            pend_dir_r  <= pwdata[`CMD_DIR_BIT];
            pend_cyc_r  <= cmd_cyc;
        end else if (start_instr) begin
            pending_r   <= 1'b0;
        end
    end

    // free running state counter, four clocks per machine cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            machine_state <= first_state;
        end else begin
            case (machine_state) // see R1
                first_state:  machine_state <= second_state; // see R2
                second_state: machine_state <= third_state; // see R3
                third_state:  machine_state <= fourth_state;
                fourth_state: machine_state <= first_state;
                default:      machine_state <= first_state;
            endcase
        end
    end

    // instruction boundaries fall on the fourth state
    always_comb begin
        start_instr = pending_r && !busy_r && (machine_state == fourth_state);
        last_mc     = busy_r && (machine_state == fourth_state) && (mc_idx_r == 4'(cycles_r - 4'h1));
        acc_start   = busy_r && is_move && (machine_state == fourth_state) && (mc_idx_r == 4'h0); // see R10
    end

    // machine cycle sequencer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_r   <= 1'b0;
            kind_r   <= `KIND_NORMAL;
            dir_r    <= 1'b0;
            cycles_r <= `MC_MIN;
            mc_idx_r <= 4'h0;
        end else if (start_instr) begin
            busy_r   <= 1'b1;
            kind_r   <= pend_kind_r;
            dir_r    <= pend_dir_r;
            mc_idx_r <= 4'h0;
            if (pend_kind_r == `KIND_NORMAL) begin
                cycles_r <= pend_cyc_r; // see R5
            end else begin
                cycles_r <= 4'({1'b0, stretch_r} + `MOVE_BASE_MC); // see R7
            end
        end else if (last_mc) begin
            busy_r   <= 1'b0;
            mc_idx_r <= 4'h0;
        end else if (busy_r && (machine_state == fourth_state)) begin
            mc_idx_r <= 4'(mc_idx_r + 4'h1);
        end
    end

    // fetch pulse in the first state of each fetching machine cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            opcode_fetch <= 1'b0;
        end else begin
            opcode_fetch <= start_instr || (busy_r && !last_mc && !is_move
                            && (machine_state == fourth_state)); // see R4
        end
    end

    // hold flag through the cycles added by stretching
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cpu_hold <= 1'b0;
        end else if (machine_state == fourth_state) begin
            cpu_hold <= busy_r && !last_mc && is_move && (mc_idx_r >= 4'h1); // see R11
        end
    end

    // external address and write data, latched for the whole access
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ext_addr    <= `DP_RST;
            ext_wdata   <= `BYTE_RST;
            ext_data_oe <= 1'b0;
        end else if (acc_start) begin
            if (kind_r == `KIND_MOVE_INDEX) begin
                ext_addr <= {port2_r, index_r}; // see R12
            end else begin
                ext_addr <= ptr_sel_r ? dp1_r : dp0_r; // see R13, see R16
            end
            ext_wdata   <= wdata_r;
            ext_data_oe <= dir_r;
        end else if (last_mc) begin
            ext_data_oe <= 1'b0; // address itself is kept, see R20
        end
    end

    // read data sampled on every strobe clock, last one wins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_r <= `BYTE_RST;
        end else if (!ext_rd_n) begin
            rdata_r <= ext_rdata; // see R21
        end
    end

    // strobe generator for the access phase
    strobe_timer #(
        .CNT_W (CNT_W)
    ) u_strobe (
        .clock     (clock),
        .rst_n     (rst_n),
        .start     (acc_start),
        .write_dir (dir_r),
        .stretch   (3'(cycles_r - `MOVE_BASE_MC)), // stretch as latched at instruction start
        .rd_n_r    (ext_rd_n),
        .wr_n_r    (ext_wr_n),
        .running_r (acc_running)
    );

endmodule : external_data_access_timing
`default_nettype wire

// >>> logic/strobe_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "ext_access_cfg.svh"

module strobe_timer #(
    parameter int CNT_W = 6
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic       write_dir,
    input  wire logic [2:0] stretch,
    output var  logic       rd_n_r,
    output var  logic       wr_n_r,
    output var  logic       running_r
);

    logic [CNT_W-1:0] cnt_r;
    logic [2:0]       stretch_r;
    logic             dir_r;
    logic [CNT_W-1:0] next_k;
    logic [2:0]       s_use;
    logic             running_nxt;
    logic             window;

    // clocks in the access phase: one per state of each access machine cycle
    function automatic logic [CNT_W-1:0] acc_clocks(input logic [2:0] s);
        acc_clocks = CNT_W'(({{(CNT_W-3){1'b0}}, s} + CNT_W'(1)) << `MC_SHIFT);
    endfunction : acc_clocks

    // strobe width 2 for no stretch, else four clocks per stretch step
    function automatic logic [CNT_W-1:0] strobe_width(input logic [2:0] s);
        strobe_width = (s == 3'h0) ? `STROBE_W_MIN : CNT_W'({{(CNT_W-3){1'b0}}, s} << `MC_SHIFT); // see R19
    endfunction : strobe_width

    function automatic logic [CNT_W-1:0] strobe_start(input logic [2:0] s);
        strobe_start = (s == 3'h0) ? `STROBE_OFS_MIN : `STROBE_OFS;
    endfunction : strobe_start

    // next clock index within the access phase and its strobe window
    always_comb begin
        s_use       = start ? stretch : stretch_r;
        next_k      = start ? '0 : CNT_W'(cnt_r + CNT_W'(1));
        running_nxt = start | (running_r && (cnt_r != CNT_W'(acc_clocks(stretch_r) - CNT_W'(1))));
        window      = running_nxt && (next_k >= strobe_start(s_use))
                      && (next_k < CNT_W'(strobe_start(s_use) + strobe_width(s_use))); // see R9
    end

    // access phase counter
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_r     <= '0;
            running_r <= 1'b0;
            stretch_r <= `STRETCH_RST;
            dir_r     <= 1'b0;
        end else begin
            cnt_r     <= next_k;
            running_r <= running_nxt;
            if (start) begin
                stretch_r <= stretch;
                dir_r     <= write_dir;
            end
        end
    end

    // active low strobes
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
        end else begin
            rd_n_r <= !(window && !(start ? write_dir : dir_r));
            wr_n_r <= !(window && (start ? write_dir : dir_r));
        end
    end

endmodule : strobe_timer
`default_nettype wire

// >>> sim/edat_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module edat_checker
    import ext_access_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire ext_addr_t         ext_addr,
    input wire byte_t             ext_wdata,
    input wire logic              ext_data_oe,
    input wire byte_t             ext_rdata,
    input wire logic              ext_rd_n,
    input wire logic              ext_wr_n,
    input wire logic              opcode_fetch,
    input wire mc_state_e         machine_state,
    input wire logic              cpu_hold,
    input wire logic              busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic       strobe_lo;
    logic [5:0] low_cnt_r;
    // either strobe asserted
    assign strobe_lo = !ext_rd_n || !ext_wr_n;
    // clocks spent in the current strobe
    always_ff @(posedge clock) begin
        if (!rst_n || !strobe_lo) begin
            low_cnt_r <= 6'h00;
        end else begin
            low_cnt_r <= low_cnt_r + 6'h01;
        end
    end
    sequence apb_setup_s;
        psel && !penable;
    endsequence
    sequence apb_access_s;
        psel && penable;
    endsequence
    state_step_a: assert property ($past(rst_n) |-> 2'(machine_state - $past(machine_state)) == 2'h1)
        else $error("machine state did not advance by one");
    fetch_first_a: assert property (opcode_fetch |-> machine_state == first_state)
        else $error("opcode fetch outside first state");
    apb_wait_a: assert property (apb_setup_s ##1 apb_access_s |=> pready && psel && penable)
        else $error("ready not in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready && !pslverr)
        else $error("ready held too long");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside ready");
    strobe_width_a: assert property ($fell(strobe_lo) |-> low_cnt_r inside {2, 4, 8, 12, 16, 20, 24, 28})
        else $error("strobe width not in table");
    addr_hold_a: assert property (strobe_lo |-> $stable(ext_addr) && busy)
        else $error("address moved during strobe");
    hold_busy_a: assert property ((cpu_hold || ext_data_oe) |-> busy)
        else $error("hold or drive outside instruction");
    oe_no_read_a: assert property (ext_data_oe |-> ext_rd_n)
        else $error("read strobe while driving data");
    busy_edge_a: assert property (($rose(busy) || $fell(busy)) |-> machine_state == first_state)
        else $error("instruction not whole machine cycles");
endmodule : edat_checker
bind external_data_access_timing edat_checker #(.ADDR_W(ADDR_W)) chk_i (.clock(clock), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_data_oe(ext_data_oe), .ext_rdata(ext_rdata), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
    .opcode_fetch(opcode_fetch), .machine_state(machine_state), .cpu_hold(cpu_hold), .busy(busy));
`default_nettype wire

// >>> sim/ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model
    import ext_access_pkg::*;
#(
    parameter int LATE = 1
) (
    input  wire logic      clock,
    input  wire ext_addr_t ext_addr,
    input  wire byte_t     ext_wdata,
    input  wire logic      ext_data_oe,
    input  wire logic      ext_rd_n,
    input  wire logic      ext_wr_n,
    output wire byte_t     ext_rdata
);
    byte_t mem [0:65535];
    byte_t last_r = 8'hA5;
    int    low_r = 0;
    // store while write strobe low, count read strobe length
    always @(posedge clock) begin
        if (!ext_wr_n && ext_data_oe)
            mem[ext_addr] <= ext_wdata;
        low_r <= ext_rd_n ? 0 : low_r + 1;
        last_r <= ext_rdata;
    end
    // slow device: valid data only after LATE clocks, else a toggling pattern
    assign ext_rdata = (!ext_rd_n && low_r >= LATE) ? mem[ext_addr] : ~last_r;
endmodule : ext_mem_model
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ext_access_cfg.svh"
module tb;
    import ext_access_pkg::*;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        ext_data_oe, ext_rd_n, ext_wr_n, opcode_fetch, cpu_hold, busy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    ext_addr_t   ext_addr, addr_seen;
    byte_t       ext_wdata, ext_rdata;
    mc_state_e   machine_state;
    int          n_fail = 0, num_checks = 0, busy_cnt = 0, fetch_cnt = 0, strb_cnt = 0, cyc = 0, hold_cnt = 0;
    int          seed = 32'hFF32;

    external_data_access_timing uut (.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_data_oe(ext_data_oe),
        .ext_rdata(ext_rdata), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .opcode_fetch(opcode_fetch),
        .machine_state(machine_state), .cpu_hold(cpu_hold), .busy(busy));
    ext_mem_model #(.LATE(1)) mem_i (.clock(clock), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .ext_data_oe(ext_data_oe), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_rdata(ext_rdata));

    // clock generator
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // counts busy clocks, fetches and strobe clocks; cuts a hang short
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
        if (opcode_fetch === 1'b1) fetch_cnt <= fetch_cnt + 1;
        if (cpu_hold === 1'b1) hold_cnt <= hold_cnt + 1;
        if (ext_rd_n === 1'b0 || ext_wr_n === 1'b0) begin
            strb_cnt <= strb_cnt + 1;
            addr_seen <= ext_addr;
        end
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n <= 20) begin
            n++;
            @(posedge clock);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        if (n > 20) chk("ready wait", 32'h0, 32'h1);
    endtask : apb

    task automatic reg_wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, {idx, 2'b00}, d, q, e);
    endtask : reg_wr

    task automatic reg_rd(input logic [9:0] idx, output logic [31:0] q);
        logic e;
        apb(1'b0, {idx, 2'b00}, 32'h0, q, e);
    endtask : reg_rd

    function automatic int strobe_w(input int s);
        return (s == 0) ? 2 : 4 * s;
    endfunction : strobe_w

    // launch one instruction and measure it at the pins
    task automatic run(input logic [5:0] cmd, input int mc, input int sw, input int nf, input int nh);
        int b0, f0, s0, h0, n;
        b0 = busy_cnt;
        h0 = hold_cnt;
        f0 = fetch_cnt;
        s0 = strb_cnt;
        n = 0;
        reg_wr(`CMD_IDX, {26'h0, cmd});
        while (busy !== 1'b1 && n < 12) begin
            @(negedge clock);
            n++;
        end
        while (busy !== 1'b0 && n < 100) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        chk("busy clocks", 32'(4 * mc), 32'(busy_cnt - b0));
        chk("fetches", 32'(nf), 32'(fetch_cnt - f0));
        chk("strobe clocks", 32'(sw), 32'(strb_cnt - s0));
        chk("hold clocks", 32'(nh), 32'(hold_cnt - h0));
    endtask : run

    // main sequence
    initial begin
        logic [31:0] q, v;
        logic        e;
        ext_addr_t   a;
        byte_t       d;
        logic [1:0]  kw, kr;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        reg_rd(`CLK_CTRL_IDX, q);
        chk("stretch reset", 32'h1, q);
        reg_rd(`PTR_SEL_IDX, q);
        chk("select reset", 32'h0, q);
        apb(1'b0, 12'h3FC, 32'h0, q, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        for (int i = 1; i <= 5; i++) run(6'(i), i, 0, i, 0);
        for (int s = 0; s < 8; s++) begin
            a = 16'($random(seed));
            d = 8'($random(seed));
            v = $random(seed);
            reg_wr(`CLK_CTRL_IDX, {v[31:3], 3'(s)});
            reg_rd(`CLK_CTRL_IDX, q);
            chk("stretch field", 32'(s), q);
            reg_wr(`PTR_SEL_IDX, v);
            reg_rd(`PTR_SEL_IDX, q);
            chk("select bit", {31'h0, v[0]}, q);
            reg_wr(`PTR_INC_IDX, 32'h0);
            reg_rd(`PTR_SEL_IDX, q);
            chk("select toggle", {31'h0, ~v[0]}, q);
            reg_wr(`DP0_IDX, {16'h0, v[0] ? a : ~a});
            reg_wr(`DP1_IDX, {16'h0, v[0] ? ~a : a});
            reg_wr(`INDEX_IDX, {24'h0, a[7:0]});
            reg_wr(`PORT2_IDX, {24'h0, a[15:8]});
            reg_wr(`WDATA_IDX, {24'h0, d});
            kw = s[0] ? `KIND_MOVE_INDEX : `KIND_MOVE_PTR;
            kr = s[0] ? `KIND_MOVE_PTR : `KIND_MOVE_INDEX;
            run({1'b1, kw, 3'h0}, s + 2, strobe_w(s), 1, 4 * s);
            chk("write address", {16'h0, a}, {16'h0, addr_seen});
            run({1'b0, kr, 3'h0}, s + 2, strobe_w(s), 1, 4 * s);
            chk("read address", {16'h0, a}, {16'h0, addr_seen});
            reg_rd(`RDATA_IDX, q);
            chk("read data", {24'h0, d}, q);
        end
        end_of_test();
    end
endmodule : tb
`default_nettype wire
